// ---- bus_if_pkg.sv ----
package bus_if_pkg;
	localparam logic [1:0] ST_HALT = 2'h0;
	localparam logic [1:0] ST_WRITE = 2'h1;
	localparam logic [1:0] ST_READ = 2'h2;
	localparam logic [1:0] ST_FETCH = 2'h3;
	localparam logic [15:0] VEC_TRAP = 16'h0024;
	localparam logic [15:0] VEC_R55 = 16'h002c;
	localparam logic [15:0] VEC_R65 = 16'h0034;
	localparam logic [15:0] VEC_R75 = 16'h003c;
	localparam logic [15:0] VEC_NONE = 16'h0000;
	// mask-set word fields
	localparam int SIM_MSK_LO = 0;
	localparam int SIM_MSE = 3;
	localparam int SIM_R75_CLR = 4;
	localparam int SIM_SOE = 6;
	localparam int SIM_SOD = 7;
	localparam logic [2:0] MASK_RST = 3'h7;
	localparam logic IE_RST = 1'b0;
	localparam logic GRANT_RST = 1'b0;
	localparam logic SOD_RST = 1'b0;
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam logic [6:0] SYNC_RST = 7'h00;

	typedef enum logic [2:0] {S_IDLE, S_T1, S_T2, S_TW, S_T3, S_HACK, S_HOLD, S_RETAKE} bus_st_e;

	typedef struct packed {
		logic [1:0] kind;
		logic io;
		logic [15:0] addr;
		logic [7:0] wdata;
	} bus_req_s;

	typedef struct packed {
		logic trap;
		logic r75;
		logic r65;
		logic r55;
		logic general_interrupt_request;
	} irq_in_s;

	typedef struct packed {
		logic take;
		logic general;
		logic [15:0] vector;
	} irq_out_s;

	typedef struct packed {
		logic ctl_oe;
		logic [7:0] high_address_bus;
		logic [7:0] ad_out;
		logic ad_oe;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic interrupt_acknowledge_n;
		logic io_m;
		logic [1:0] bus_cycle_status;
	} bus_pins_s;
endpackage : bus_if_pkg

// ---- cpu_bus_if.sv ----
// Summary of operation
// RULE_01: upper address carries memory address high byte, or port number in io cycles.
// RULE_02: shared lines carry low address in first clock, data in later clocks.
// RULE_03: latch strobe pulses in first clock; peripherals latch on its fall.
// RULE_04: address, data, strobes and io select float while halted or granted.
// RULE_05: status encodes 00 halt, 01 write, 10 read, 11 fetch.
// RULE_06: read strobe low while the addressed location must drive data in.
// RULE_07: write data stays valid through the write strobe trailing edge.
// RULE_08: wait clocks inserted while ready samples low, then cycle completes.
// RULE_09: hold, ready and interrupt inputs pass through synchronizers first.
// RULE_10: hold releases buses after current cycle; retaken only after request drops.
// RULE_11: grant rises before bus floats next clock; retake half clock after grant falls.
// RULE_12: general request sampled only in last instruction clock; suppresses increment.
// RULE_13: interrupt enable cleared by reset and on every accepted interrupt.
// RULE_14: acknowledge strobe replaces read strobe in next cycle after general interrupt.
// RULE_15: restarts sampled like general request; priority 7.5, 6.5, 5.5, general.
// RULE_16: trap ignores masks and enable, highest priority of all.
// RULE_17: reset zeroes program counter, clears enable and grant, keeps other state; code also sets all masks, clears serial output and 7.5 latch.
// RULE_18: reset output asserted, clock synchronous, while reset is applied.
// RULE_19: mask read copies serial input into accumulator bit 7.
// RULE_20: serial output changes only by mask set instruction, held otherwise; code also clears it on reset.
// RULE_21: io select high for io space, low for memory.
// RULE_22: processor clock is oscillator halved, two nonoverlapping phases, second output.
// RULE_23: vectors trap 24, 5.5 2c, 6.5 34, 7.5 3c hex.
// RULE_24: 5.5 and 6.5 level sensitive; 7.5 rising edge latched until cleared.
// RULE_25: trap needs level held, and a new rising edge to recur.
module cpu_bus_if (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_req_valid,
	input wire bus_if_pkg::bus_req_s i_req,
	output logic o_req_ready,
	output logic [7:0] o_rdata,
	output logic o_done,
	input wire logic i_halt,
	input wire logic [7:0] i_ad,
	output bus_if_pkg::bus_pins_s o_bus,
	input wire logic i_ready,
	input wire logic i_hold,
	output logic o_bus_grant,
	input wire bus_if_pkg::irq_in_s i_irq,
	input wire logic i_last_clk,
	input wire logic i_ie_set,
	input wire logic i_ie_clr,
	output logic o_ie,
	output bus_if_pkg::irq_out_s o_irq,
	input wire logic i_sim_wr,
	input wire logic [7:0] i_sim_data,
	input wire logic i_rim,
	output logic [7:0] o_rim_data,
	input wire logic i_serial_in_line,
	output logic o_serial_out_line,
	output logic o_reset_out,
	output logic o_phi1,
	output logic o_sys_clk
);
	import bus_if_pkg::*;

	logic phase_q;
	logic tick;
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	logic hold_s;
	logic rdy_s;
	irq_in_s irq_s;
	bus_st_e st_q;
	bus_req_s req_q;
	logic interrupt_acknowledge_n_cyc_q;
	logic grant_q;
	logic flt;
	logic active;
	logic strobe;
	logic is_wr;
	logic ie_q;
	logic [2:0] mask_q;
	logic r75_q;
	logic trap_arm_q;
	logic [1:0] prev_q;
	logic interrupt_acknowledge_n_pend_q;
	logic sod_q;
	logic reset_out_q;
	logic [7:0] rdata_q;
	logic [7:0] rim_q;
	logic done_q;
	irq_out_s irq_q;
	irq_out_s irq_d;
	logic trap_pend;
	logic p75;
	logic p65;
	logic p55;
	logic pint;
	logic accept;

	// half-rate processor clock
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			phase_q <= 1'b0;
		end else if (i_ce) begin
			phase_q <= ~phase_q; // see RULE_22
		end
	end
	assign tick = i_ce & phase_q;
	assign o_phi1 = ~phase_q;
	assign o_sys_clk = phase_q; // see RULE_22

	// two-stage synchronizers
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
		end else if (i_ce) begin
			sync1_q <= {i_hold, i_ready, i_irq}; // see RULE_09
			sync2_q <= sync1_q;
		end
	end
	assign hold_s = sync2_q[6];
	assign rdy_s = sync2_q[5];
	assign irq_s = irq_in_s'(sync2_q[4:0]);

	// machine cycle sequencer
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_q <= S_IDLE;
		end else if (tick) begin
			unique case (st_q)
				S_IDLE: begin
					if (hold_s) begin
						st_q <= S_HACK; // see RULE_10
					end else if (i_req_valid && !i_halt) begin
						st_q <= S_T1;
					end
				end
				S_T1: st_q <= S_T2;
				S_T2, S_TW: st_q <= rdy_s ? S_T3 : S_TW; // see RULE_08
				S_T3: st_q <= S_IDLE;
				S_HACK: st_q <= S_HOLD; // see RULE_11
				S_HOLD: begin
					if (!hold_s) begin
						st_q <= S_RETAKE; // see RULE_10
					end
				end
				S_RETAKE: st_q <= S_IDLE;
			endcase
		end
	end
	assign o_req_ready = tick && st_q == S_IDLE && !hold_s && !i_halt;

	// request capture
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			req_q <= '0;
			interrupt_acknowledge_n_cyc_q <= 1'b0;
		end else if (o_req_ready && i_req_valid) begin
			req_q <= i_req;
			interrupt_acknowledge_n_cyc_q <= interrupt_acknowledge_n_pend_q && i_req.kind != ST_WRITE; // see RULE_14
		end
	end

	// grant flag
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			grant_q <= GRANT_RST; // see RULE_17
		end else if (tick) begin
			if (st_q == S_IDLE && hold_s) begin
				grant_q <= 1'b1; // see RULE_11
			end else if (st_q == S_HOLD && !hold_s) begin
				grant_q <= 1'b0;
			end
		end
	end
	assign o_bus_grant = grant_q;

	// read data and completion
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rdata_q <= RDATA_RST;
			done_q <= 1'b0;
		end else if (i_ce) begin
			done_q <= tick && st_q == S_T3;
			if (!phase_q && st_q == S_T3 && !is_wr) begin
				rdata_q <= i_ad;
			end
		end
	end
	assign o_rdata = rdata_q;
	assign o_done = done_q;

	// pin drive
	assign flt = st_q == S_HOLD || (st_q == S_RETAKE && !phase_q) || (i_halt && st_q == S_IDLE); // see RULE_04
	assign active = st_q == S_T2 || st_q == S_TW || st_q == S_T3;
	assign strobe = active && !(st_q == S_T3 && phase_q); // see RULE_07
	assign is_wr = req_q.kind == ST_WRITE;
	always_comb begin
		o_bus.ctl_oe = !flt;
		o_bus.high_address_bus = req_q.io ? req_q.addr[7:0] : req_q.addr[15:8]; // see RULE_01
		o_bus.ad_out = (st_q == S_T1) ? req_q.addr[7:0] : req_q.wdata; // see RULE_02
		o_bus.ad_oe = !flt && (st_q == S_T1 || (is_wr && active)); // see RULE_07
		o_bus.ale = !flt && st_q == S_T1; // see RULE_03
		o_bus.rd_n = !(strobe && !is_wr && !interrupt_acknowledge_n_cyc_q); // see RULE_06
		o_bus.wr_n = !(strobe && is_wr);
		o_bus.interrupt_acknowledge_n = !(strobe && interrupt_acknowledge_n_cyc_q); // see RULE_14
		o_bus.io_m = req_q.io; // see RULE_21
		o_bus.bus_cycle_status = (i_halt && st_q == S_IDLE) ? ST_HALT : req_q.kind; // see RULE_05
	end

	// interrupt arbitration
	assign trap_pend = trap_arm_q && irq_s.trap; // see RULE_25
	assign p75 = r75_q && !mask_q[2] && ie_q;
	assign p65 = irq_s.r65 && !mask_q[1] && ie_q;
	assign p55 = irq_s.r55 && !mask_q[0] && ie_q;
	assign pint = irq_s.general_interrupt_request && ie_q;
	always_comb begin
		irq_d = '0;
		if (trap_pend) begin
			irq_d.vector = VEC_TRAP; // see RULE_16
		end else if (p75) begin
			irq_d.vector = VEC_R75; // see RULE_15
		end else if (p65) begin
			irq_d.vector = VEC_R65; // see RULE_23
		end else if (p55) begin
			irq_d.vector = VEC_R55;
		end else begin
			irq_d.vector = VEC_NONE;
			irq_d.general = pint;
		end
		irq_d.take = trap_pend | p75 | p65 | p55 | pint;
	end
	assign accept = i_ce && i_last_clk && irq_d.take; // see RULE_12

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			irq_q <= '0;
		end else if (i_ce) begin
			irq_q <= i_last_clk ? irq_d : '0;
		end
	end
	assign o_irq = irq_q;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ie_q <= IE_RST; // see RULE_13
		end else if (accept) begin
			ie_q <= 1'b0;
		end else if (i_ce && i_ie_set) begin
			ie_q <= 1'b1;
		end else if (i_ce && i_ie_clr) begin
			ie_q <= 1'b0;
		end
	end
	assign o_ie = ie_q;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			interrupt_acknowledge_n_pend_q <= 1'b0;
		end else if (accept && irq_d.general) begin
			interrupt_acknowledge_n_pend_q <= 1'b1; // see RULE_14
		end else if (o_req_ready && i_req_valid && i_req.kind != ST_WRITE) begin
			interrupt_acknowledge_n_pend_q <= 1'b0;
		end
	end

	// edge latches, set wins
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			prev_q <= 2'h0;
			r75_q <= 1'b0;
			trap_arm_q <= 1'b0;
		end else if (i_ce) begin
			prev_q <= {irq_s.trap, irq_s.r75};
			if (irq_s.r75 && !prev_q[0]) begin
				r75_q <= 1'b1; // see RULE_24
			end else if ((accept && !trap_pend && p75) || (i_sim_wr && i_sim_data[SIM_R75_CLR])) begin
				r75_q <= 1'b0;
			end
			if (irq_s.trap && !prev_q[1]) begin
				trap_arm_q <= 1'b1; // see RULE_25
			end else if (accept && trap_pend) begin
				trap_arm_q <= 1'b0;
			end
		end
	end

	// masks, serial lines
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			mask_q <= MASK_RST;
			sod_q <= SOD_RST;
			rim_q <= 8'h00;
		end else if (i_ce) begin
			if (i_sim_wr && i_sim_data[SIM_MSE]) begin
				mask_q <= i_sim_data[SIM_MSK_LO +: 3];
			end
			if (i_sim_wr && i_sim_data[SIM_SOE]) begin
				sod_q <= i_sim_data[SIM_SOD]; // see RULE_20
			end
			if (i_rim) begin
				rim_q <= {i_serial_in_line, r75_q, irq_s.r65, irq_s.r55, ie_q, mask_q}; // see RULE_19
			end
		end
	end
	assign o_serial_out_line = sod_q;
	assign o_rim_data = rim_q;

	always_ff @(posedge i_clk) begin
		reset_out_q <= i_srst; // see RULE_18
	end
	assign o_reset_out = reset_out_q; // see RULE_18

	default clocking dc @(posedge i_clk); endclocking
	default disable iff (i_srst || !i_ce);

	AST_ALE_FIRST: assert property (o_bus.ale |-> st_q == S_T1 && o_bus.ad_oe) else $error("ale outside first clock"); // RULE_03
	AST_FLOAT: assert property (st_q == S_HOLD |-> !o_bus.ctl_oe && !o_bus.ad_oe && grant_q) else $error("bus driven in hold"); // RULE_04
	AST_READ_STATUS: assert property (!o_bus.rd_n |-> o_bus.bus_cycle_status[1] && !o_bus.ad_oe) else $error("read status wrong"); // RULE_05
	AST_WR_DATA: assert property ($rose(o_bus.wr_n) && st_q == S_T3 |-> o_bus.ad_oe ##1 st_q == S_IDLE) else $error("write data dropped"); // RULE_07
	AST_WAIT: assert property (tick && st_q == S_T2 && !rdy_s |=> st_q == S_TW [*2]) else $error("no wait clock"); // RULE_08
	AST_GRANT: assert property ($rose(grant_q) |-> o_bus.ctl_oe ##2 !o_bus.ctl_oe) else $error("float not next clock"); // RULE_11
	AST_RETAKE: assert property ($fell(grant_q) |-> !o_bus.ctl_oe ##1 o_bus.ctl_oe) else $error("retake not half clock"); // RULE_11
	AST_IE_CLR: assert property (accept |=> !ie_q && o_irq.take) else $error("enable kept on accept"); // RULE_13
	AST_TRAP_VEC: assert property (accept && trap_pend |=> o_irq.vector == VEC_TRAP && !o_irq.general) else $error("trap vector"); // RULE_16
	AST_INTERRUPT_ACKNOWLEDGE_N: assert property (!o_bus.interrupt_acknowledge_n |-> o_bus.rd_n && o_bus.wr_n && o_bus.bus_cycle_status[1]) // RULE_14
		else $error("ack with read");
	AST_IO_HIGH: assert property (o_bus.ale && o_bus.io_m |-> o_bus.high_address_bus == o_bus.ad_out) else $error("port number"); // RULE_01
	AST_SYNC: assert property ($rose(i_hold) ##1 i_hold |-> !hold_s) else $error("hold not synchronized"); // RULE_09

	COV_WAIT: cover property (st_q == S_TW ##2 st_q == S_T3);
	COV_HOLD: cover property ($rose(grant_q) ##[1:40] $fell(grant_q));
	COV_INTERRUPT_ACKNOWLEDGE_N: cover property (!o_bus.interrupt_acknowledge_n);
	COV_TRAP: cover property (accept && trap_pend);
endmodule : cpu_bus_if

// ---- mem_model.sv ----
module mem_model (
	input wire logic i_clk,
	input wire bus_if_pkg::bus_pins_s i_bus,
	input wire logic [3:0] i_waits,
	output logic [7:0] o_ad,
	output logic o_ready,
	output logic [15:0] o_addr,
	output logic o_io,
	output logic [1:0] o_status,
	output logic [7:0] o_wdata,
	output logic o_ack_seen,
	output logic o_rd_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	import bus_if_pkg::*;
	logic [4:0] cnt_q;
	logic drive;
	assign drive = (i_bus.ctl_oe & ~i_bus.rd_n) | ~i_bus.interrupt_acknowledge_n;
	initial begin
		o_ready = 1'b1;
		cnt_q = '0;
		o_ad = '0;
	end
	// address, space and status as last seen while the strobe stands
	always @(posedge i_clk) begin
		if (i_bus.ale) begin
			o_addr <= {i_bus.high_address_bus, i_bus.ad_out};
			o_io <= i_bus.io_m;
			o_status <= i_bus.bus_cycle_status;
		end
	end
	// write data taken at strobe trailing edge
	always @(posedge i_bus.wr_n) o_wdata = i_bus.ad_oe ? i_bus.ad_out : 8'hxx;
	// slow device holds ready low from the address phase
	always @(posedge i_clk) begin
		if (i_bus.ale) begin
			cnt_q <= '0;
			o_ready <= (i_waits == 4'h0);
		end else if (!o_ready) begin
			cnt_q <= cnt_q + 5'h01;
			if (cnt_q >= {i_waits, 1'b0} + 5'h04) o_ready <= 1'b1;
		end
	end
	// answer data, all ones on acknowledge, scrambled while released
	always @(posedge i_clk) begin
		o_ad <= !drive ? ~o_ad : !i_bus.interrupt_acknowledge_n ? 8'hff : o_io ? ~o_addr[7:0] : o_addr[7:0] ^ 8'ha5;
		o_ack_seen <= !i_bus.ale & (o_ack_seen | ~i_bus.interrupt_acknowledge_n);
		o_rd_seen <= !i_bus.ale & (o_rd_seen | (drive & i_bus.interrupt_acknowledge_n));
	end
endmodule : mem_model

// ---- testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import bus_if_pkg::*;
	logic i_clk, i_srst, i_ce, i_req_valid, i_halt, i_hold, i_last_clk, i_ie_set, i_ie_clr, i_sim_wr, i_rim;
	logic i_serial_in_line, i_ready, o_req_ready, o_done, o_bus_grant, o_ie, o_serial_out_line;
	logic o_reset_out, o_phi1, o_sys_clk, m_io, ack_seen, rd_seen;
	logic [7:0] i_sim_data, o_rdata, o_rim_data, m_ad, m_wdata, ad_wire;
	logic [15:0] m_addr;
	logic [1:0] m_status;
	logic [3:0] waits;
	bus_req_s i_req;
	irq_in_s i_irq;
	bus_pins_s o_bus;
	irq_out_s o_irq;
	int err_total = 0;
	int samples_checked = 0;
	int n, base;
	localparam logic [15:0] VECS [5] = '{VEC_NONE, VEC_R55, VEC_R65, VEC_R75, VEC_TRAP};
	localparam logic [38:0] ROWS [6] = '{{ST_READ, 1'b0, 16'h1234, 8'h00, 4'h0, 8'h91},
		{ST_FETCH, 1'b0, 16'hfff0, 8'h00, 4'h0, 8'h55}, {ST_WRITE, 1'b0, 16'h8001, 8'h5a, 4'h0, 8'h5a},
		{ST_READ, 1'b1, 16'h4242, 8'h00, 4'h0, 8'hbd}, {ST_WRITE, 1'b1, 16'h9999, 8'hc3, 4'h1, 8'hc3},
		{ST_READ, 1'b0, 16'h00ff, 8'h00, 4'h3, 8'h5a}};
	assign ad_wire = o_bus.ad_oe ? o_bus.ad_out : m_ad;
	cpu_bus_if i_cpu_bus_if (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_req_valid(i_req_valid), .i_req(i_req),
		.o_req_ready(o_req_ready), .o_rdata(o_rdata), .o_done(o_done), .i_halt(i_halt), .i_ad(ad_wire),
		.o_bus(o_bus), .i_ready(i_ready), .i_hold(i_hold), .o_bus_grant(o_bus_grant), .i_irq(i_irq),
		.i_last_clk(i_last_clk), .i_ie_set(i_ie_set), .i_ie_clr(i_ie_clr), .o_ie(o_ie), .o_irq(o_irq),
		.i_sim_wr(i_sim_wr), .i_sim_data(i_sim_data), .i_rim(i_rim), .o_rim_data(o_rim_data),
		.i_serial_in_line(i_serial_in_line), .o_serial_out_line(o_serial_out_line), .o_reset_out(o_reset_out),
		.o_phi1(o_phi1), .o_sys_clk(o_sys_clk));
	mem_model i_mem_model (.i_clk(i_clk), .i_bus(o_bus), .i_waits(waits), .o_ad(m_ad), .o_ready(i_ready),
		.o_addr(m_addr), .o_io(m_io), .o_status(m_status), .o_wdata(m_wdata), .o_ack_seen(ack_seen),
		.o_rd_seen(rd_seen));
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	task automatic results;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: value %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: bit %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic wait_on(ref logic s, input logic v);
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (s !== v && n < 200);
		chk_bit(s, v);
	endtask : wait_on
	task automatic bus_op(input bus_req_s r);
		i_req <= r;
		i_req_valid <= 1'b1;
		wait_on(o_req_ready, 1'b1);
		@(posedge i_clk);
		i_req_valid <= 1'b0;
		wait_on(o_done, 1'b1);
	endtask : bus_op
	task automatic fire;
		i_last_clk <= 1'b1;
		@(posedge i_clk);
		i_last_clk <= 1'b0;
		@(negedge i_clk);
	endtask : fire
	task automatic do_reset;
		i_srst <= 1'b1;
		repeat (5) @(posedge i_clk);
		@(negedge i_clk);
		chk_bit(o_reset_out, 1'b1);
		chk_bit(o_ie | o_bus_grant, 1'b0);
		@(posedge i_clk);
		i_srst <= 1'b0;
		repeat (2) @(negedge i_clk);
		chk_bit(o_reset_out, 1'b0);
		@(posedge i_clk);
	endtask : do_reset
	initial begin
		#100000;
		err_total++;
		results;
	end
	initial begin
		bus_req_s rq;
		logic ph;
		{i_req_valid, i_halt, i_hold, i_last_clk, i_ie_set, i_ie_clr, i_sim_wr, i_rim, i_serial_in_line} = '0;
		i_srst = 1'b1;
		i_ce = 1'b1;
		i_req = '0;
		i_irq = '0;
		i_sim_data = '0;
		waits = '0;
		do_reset;
		for (int i = 0; i < 6; i++) begin
			rq = ROWS[i][38:12];
			waits <= ROWS[i][11:8];
			bus_op(rq);
			chk_val(m_addr, rq.addr);
			chk_val(m_status, rq.kind);
			chk_bit(m_io, rq.io);
			chk_bit(rd_seen, rq.kind != ST_WRITE);
			if (rq.kind == ST_WRITE) chk_val(m_wdata, ROWS[i][7:0]);
			else chk_val(o_rdata, ROWS[i][7:0]);
			if (waits == 4'h0) base = n;
			else chk_bit(n > base, 1'b1);
			@(posedge i_clk);
		end
		i_hold <= 1'b1;
		wait_on(o_bus_grant, 1'b1);
		repeat (2) @(posedge i_clk);
		i_req_valid <= 1'b1;
		repeat (8) begin
			@(negedge i_clk);
			chk_bit(o_req_ready | o_bus.ctl_oe | o_bus.ad_oe | ~o_bus_grant, 1'b0);
		end
		@(posedge i_clk);
		i_req_valid <= 1'b0;
		i_hold <= 1'b0;
		wait_on(o_bus_grant, 1'b0);
		@(negedge i_clk);
		chk_bit(o_bus.ctl_oe, 1'b1);
		@(posedge i_clk);
		i_halt <= 1'b1;
		repeat (3) @(negedge i_clk);
		chk_bit(o_bus.ctl_oe | o_bus.ad_oe, 1'b0);
		chk_val(o_bus.bus_cycle_status, ST_HALT);
		ph = o_sys_clk;
		@(negedge i_clk);
		chk_bit(o_sys_clk, ~ph);
		chk_bit(o_phi1, ph);
		@(posedge i_clk);
		i_ce <= 1'b0;
		@(negedge i_clk);
		ph = o_sys_clk;
		repeat (3) @(negedge i_clk);
		chk_bit(o_sys_clk, ph);
		@(posedge i_clk);
		i_ce <= 1'b1;
		i_halt <= 1'b0;
		i_sim_wr <= 1'b1;
		i_sim_data <= 8'h08;
		@(posedge i_clk);
		i_sim_wr <= 1'b0;
		for (int i = 4; i >= 0; i--) begin
			i_irq <= 5'((6'h01 << (i + 1)) - 6'h01);
			i_ie_set <= 1'b1;
			@(posedge i_clk);
			i_ie_set <= 1'b0;
			repeat (4) @(posedge i_clk);
			fire;
			chk_bit(o_irq.take, 1'b1);
			chk_val(o_irq.vector, VECS[i]);
			chk_bit(o_irq.general, i == 0);
			chk_bit(o_ie, 1'b0);
			@(posedge i_clk);
			i_irq <= '0;
			repeat (3) @(posedge i_clk);
		end
		bus_op({ST_FETCH, 1'b0, 16'h0100, 8'h00});
		chk_bit(ack_seen & ~rd_seen, 1'b1);
		chk_val(o_rdata, 8'hff);
		@(posedge i_clk);
		i_irq <= 5'h11;
		fire;
		chk_bit(o_irq.take, 1'b0);
		repeat (3) @(posedge i_clk);
		fire;
		chk_val(o_irq.vector, o_irq.take ? VEC_TRAP : 16'hffff);
		@(posedge i_clk);
		fire;
		chk_bit(o_irq.take, 1'b0);
		@(posedge i_clk);
		i_irq <= 5'h08;
		i_ie_set <= 1'b1;
		@(posedge i_clk);
		i_irq <= '0;
		i_ie_set <= 1'b0;
		repeat (4) @(posedge i_clk);
		fire;
		chk_val(o_irq.vector, o_irq.take ? VEC_R75 : 16'hffff);
		@(posedge i_clk);
		i_irq <= 5'h08;
		i_ie_set <= 1'b1;
		@(posedge i_clk);
		i_irq <= '0;
		i_ie_set <= 1'b0;
		repeat (4) @(posedge i_clk);
		i_sim_wr <= 1'b1;
		i_sim_data <= 8'h10;
		@(posedge i_clk);
		i_sim_wr <= 1'b0;
		fire;
		chk_bit(o_irq.take, 1'b0);
		@(posedge i_clk);
		i_ie_clr <= 1'b1;
		@(posedge i_clk);
		i_ie_clr <= 1'b0;
		@(negedge i_clk);
		chk_bit(o_ie, 1'b0);
		@(posedge i_clk);
		i_sim_wr <= 1'b1;
		i_sim_data <= 8'hc0;
		@(posedge i_clk);
		i_sim_data <= 8'h00;
		@(posedge i_clk);
		i_sim_wr <= 1'b0;
		i_serial_in_line <= 1'b1;
		i_rim <= 1'b1;
		@(posedge i_clk);
		i_rim <= 1'b0;
		i_ie_set <= 1'b1;
		@(negedge i_clk);
		chk_bit(o_serial_out_line, 1'b1);
		chk_val(o_rim_data, 8'h80);
		@(posedge i_clk);
		i_ie_set <= 1'b0;
		do_reset;
		results;
	end
endmodule : testbench
